// ==== inc/uhi_pkg.sv ====
// Package: register map, field layout, reset values and timing constants of the IRQ generator
package uhi_pkg;

    // Register byte offsets
    localparam logic [11:0] REG_HW_MODE = 12'h000;
    localparam logic [11:0] REG_EDGE_CNT = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_ENABLE = 12'h00c;
    localparam logic [11:0] REG_CAT_BASE = 12'h010; // Done map, AND mask, OR mask per category
    localparam logic [11:0] REG_CAT_STRIDE = 12'h00c;
    localparam logic [11:0] REG_DONE_OFS = 12'h000;
    localparam logic [11:0] REG_AND_OFS = 12'h004;
    localparam logic [11:0] REG_OR_OFS = 12'h008;
    localparam logic [11:0] REG_ATL_TMO = 12'h034;

    // Mode control fields
    localparam int MODE_GIE_BIT = 0;
    localparam int MODE_EDGE_BIT = 1;
    localparam int MODE_POL_BIT = 2;
    localparam logic [2:0] MODE_RST = 3'h0; // Disabled, level, active low

    // Edge count fields
    localparam int EC_PW_LSB = 0;
    localparam int EC_SP_LSB = 24;

    // Status bit positions
    localparam int ST_W = 16;
    localparam int ST_DMA_BIT = 3;
    localparam int ST_CAT_LSB = 7; // Isochronous, interrupt, bulk list in order

    // Descriptor categories
    localparam int NCAT = 3;
    localparam int CAT_ATL = 2;

    // Bulk timeout fields
    localparam int TMO_EN_BIT = 31;

    // Timing
    localparam int CLK_NS = 4;
    localparam int PULSE_MAX_NS = 1000000;
    localparam int PULSE_DEF_NS = 500;
    localparam int PW_SCALE_CYC = PULSE_MAX_NS / (CLK_NS * 65536);
    localparam logic [15:0] PW_DEF_CODE = 16'(PULSE_DEF_NS / (CLK_NS * PW_SCALE_CYC) - 1);
    localparam int SPACE_UNIT_NS = 1000;
    localparam int SPACE_UNIT_CYC = SPACE_UNIT_NS / CLK_NS;
    localparam int US_NS = 1000;
    localparam logic [7:0] US_CYC = 8'(US_NS / CLK_NS);

    // Pulse shaper states, Gray along idle, active, gap
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_ACT = 2'b01,
        SH_GAP = 2'b11
    } uhi_sh_state_t;

endpackage

// ==== inc/uhi_shape_if.sv ====
// Interface between the register core and the output pulse shaper
`timescale 1ns/1ns
`default_nettype none
interface uhi_shape_if;
    logic raw;           // Global enable and any enabled pending status
    logic trig;          // One-cycle pulse on a newly set enabled status bit
    logic gie;
    logic edge_sel;
    logic pol_high;
    logic [15:0] pw_code;
    logic [7:0] sp_code;
    logic pin;           // Registered output pin level

    modport core (output raw, trig, gie, edge_sel, pol_high, pw_code, sp_code, input pin);
    modport shaper (input raw, trig, gie, edge_sel, pol_high, pw_code, sp_code, output pin);
endinterface
`default_nettype wire

// ==== rtl/uhi_irq_shaper.sv ====
// Output shaper: level or pulse signalling, polarity, pulse width and spacing
`timescale 1ns/1ns
`default_nettype none
module uhi_irq_shaper
    import uhi_pkg::*;
#(
    parameter int PW_SCALE = PW_SCALE_CYC,
    parameter int SP_UNIT = SPACE_UNIT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Core side
    uhi_shape_if.shaper sif
);

    typedef struct packed {
        uhi_sh_state_t st;
        logic [31:0] cnt;
        logic pend;
        logic pin;
    } uhi_sh_t;

    uhi_sh_t q_r, q_nxt;
    logic start;
    logic leave;

    // Next state of the shaper
    always_comb begin
        q_nxt = q_r;
        start = 1'b0;
        leave = 1'b0;
        if (sif.trig && sif.edge_sel) begin
            q_nxt.pend = 1'b1; // Events during a pulse or gap merge into one
        end
        case (q_r.st)
            SH_IDLE: begin
                start = sif.edge_sel ? (q_r.pend && sif.gie) : sif.raw;
                if (start) begin
                    q_nxt.st = SH_ACT;
                    q_nxt.pend = 1'b0;
                    q_nxt.cnt = 32'((32'(sif.pw_code) + 32'd1) * 32'(PW_SCALE) - 1);
                end
            end
            SH_ACT: begin
                // Pulse runs its full count; clearing status cannot cut it
                if (sif.edge_sel) begin
                    leave = (q_r.cnt == 32'h0);
                    q_nxt.cnt = q_r.cnt - 32'd1;
                end else begin
                    leave = !sif.raw; // Holds until all contributing bits cleared
                end
                if (leave) begin
                    if (sif.sp_code != 8'h00) begin
                        q_nxt.st = SH_GAP; // Minimum spacing before next activation
                        q_nxt.cnt = 32'(32'(sif.sp_code) * 32'(SP_UNIT) - 1);
                    end else begin
                        q_nxt.st = SH_IDLE;
                    end
                end
            end
            SH_GAP: begin
                q_nxt.cnt = q_r.cnt - 32'd1;
                if (q_r.cnt == 32'h0) begin
                    q_nxt.st = SH_IDLE;
                end
            end
            default: begin
                q_nxt.st = SH_IDLE;
            end
        endcase
        // Active level only with global enable; polarity bit 1 means active high
        q_nxt.pin = ((q_nxt.st == SH_ACT) && sif.gie) ? sif.pol_high : !sif.pol_high;
    end

    // State register; pin idles high so reset shows inactive active-low level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '{st: SH_IDLE, cnt: 32'h0, pend: 1'b0, pin: 1'b1};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sif.pin = q_r.pin;

endmodule // uhi_irq_shaper
`default_nettype wire

// ==== rtl/uhi_irq_gen.sv ====
// Interrupt generator top: APB registers, status, descriptor masks, bulk timeout
//
// Notes on behaviour
// - Interrupt output asserts only while global enable, mode bit 0, is set.
// - Mode bit 1 selects level or pulse signalling of the output.
// - Mode bit 2 selects active-low or active-high output polarity.
// - After reset: level signalling, active low.
// - Pulse width from edge count bits 15:0; FFFFh about 1 ms, here 65536 x 3 cycles of 4 ns, about 786 us; default 500 ns.
// - Edge count bits 31:24 set minimum spacing; events meanwhile merge.
// - Every event sets its status bit; disabled sources do not drive output.
// - Writing one clears a status bit; zero leaves it alone.
// - Level mode holds output until all contributing status bits cleared.
// - Clearing write never shortens a started pulse.
// - Interrupt generation keeps running while main clocks are stopped.
// - Status shows only which events occurred, not order or time.
// - Done bit with OR mask bit set raises IRQ; OR beats AND.
// - Otherwise IRQ only when all AND-selected done bits are set.
// - Each AND/OR mask pair applies only within its own category.
// - With bulk interval option, bulk IRQ only at timeout expiry.
// - Done maps show which descriptors completed when IRQ raised.
// - DMA end-of-transfer event lands in status bit 3.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module uhi_irq_gen
    import uhi_pkg::*;
#(
    parameter int DONE_W = 32,
    parameter int PW_SCALE = PW_SCALE_CYC,
    parameter int SP_UNIT = SPACE_UNIT_CYC
) (
    // Clock and reset; pclk is the always-on clock kept alive in suspend
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event sources, one-cycle pulses
    input wire logic [ST_W-1:0] event_in,
    input wire logic dma_done_event,
    input wire logic [DONE_W-1:0] iso_done_set,
    input wire logic [DONE_W-1:0] int_done_set,
    input wire logic [DONE_W-1:0] async_bulk_list_done_set,
    // Interrupt pin to the processor
    output logic irq
);

    typedef struct packed {
        logic [2:0] mode;
        logic [15:0] pw;
        logic [7:0] sp;
        logic [ST_W-1:0] st;
        logic [ST_W-1:0] en;
        logic [NCAT-1:0][DONE_W-1:0] done;
        logic [NCAT-1:0][DONE_W-1:0] andm;
        logic [NCAT-1:0][DONE_W-1:0] orm;
        logic [NCAT-1:0] and_q;
        logic [15:0] tmo;
        logic tmo_en;
        logic [15:0] tmr_us;
        logic [7:0] tmr_div;
        logic atl_pend;
        logic trig;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } uhi_regs_t;

    uhi_regs_t r_r, r_nxt;
    uhi_shape_if sif ();

    logic [NCAT-1:0][DONE_W-1:0] done_set;
    logic [NCAT-1:0] or_new;
    logic [NCAT-1:0] and_hit;
    logic [NCAT-1:0] cat_fire;

    assign done_set[0] = iso_done_set;
    assign done_set[1] = int_done_set;
    assign done_set[CAT_ATL] = async_bulk_list_done_set;

    // Per-category mask evaluation, each pair sees only its own done map
    genvar c;
    generate
        for (c = 0; c < NCAT; c++) begin : g_cat
            // New done bits under the OR mask fire at once, ahead of AND
            assign or_new[c] = |(done_set[c] & r_r.orm[c]);
            // AND fires only when every selected done bit is set
            assign and_hit[c] = (r_r.andm[c] != '0) &&
                                ((r_r.done[c] & r_r.andm[c]) == r_r.andm[c]);
            assign cat_fire[c] = or_new[c] || (and_hit[c] && !r_r.and_q[c]);
        end
    endgenerate

    // Read mux over the register map
    function automatic logic [32:0] rd_mux(input uhi_regs_t r, input logic [11:0] a);
        logic [32:0] v;
        v = {1'b1, 32'h0};
        case (a)
            REG_HW_MODE: v = {1'b0, 29'h0, r.mode};
            REG_EDGE_CNT: v = {1'b0, r.sp, 8'h00, r.pw};
            REG_STATUS: v = {1'b0, 16'h0, r.st};
            REG_ENABLE: v = {1'b0, 16'h0, r.en};
            REG_ATL_TMO: v = {1'b0, r.tmo_en, 15'h0, r.tmo};
            default: begin
                for (int k = 0; k < NCAT; k++) begin
                    if (a == 12'(REG_CAT_BASE + REG_CAT_STRIDE * 12'(k) + REG_DONE_OFS)) begin
                        v = {1'b0, 32'(r.done[k])};
                    end
                    if (a == 12'(REG_CAT_BASE + REG_CAT_STRIDE * 12'(k) + REG_AND_OFS)) begin
                        v = {1'b0, 32'(r.andm[k])};
                    end
                    if (a == 12'(REG_CAT_BASE + REG_CAT_STRIDE * 12'(k) + REG_OR_OFS)) begin
                        v = {1'b0, 32'(r.orm[k])};
                    end
                end
            end
        endcase
        return v;
    endfunction

    // Next state of the register core
    always_comb begin
        logic wr;
        logic [ST_W-1:0] set_vec;
        logic [ST_W-1:0] clr_vec;
        logic [32:0] rd;
        logic tick_us;
        logic expire;
        logic [11:0] ca;
        r_nxt = r_r;
        wr = psel && penable && pwrite && r_r.pready;
        set_vec = '0;
        clr_vec = '0;
        rd = rd_mux(r_r, paddr);
        tick_us = 1'b0;
        expire = 1'b0;
        ca = 12'h0;

        // APB: answer in the first access cycle, data and error registered
        r_nxt.pready = psel && !penable;
        r_nxt.prdata = (psel && !penable && !pwrite) ? rd[31:0] : 32'h0;
        r_nxt.pslverr = psel && !penable && rd[32];

        // Bulk interval timer in microsecond steps
        if (r_r.tmo_en) begin
            tick_us = (r_r.tmr_div == US_CYC - 8'd1);
            r_nxt.tmr_div = tick_us ? 8'h00 : r_r.tmr_div + 8'd1;
            if (tick_us) begin
                expire = (r_r.tmr_us >= r_r.tmo);
                r_nxt.tmr_us = expire ? 16'h0 : r_r.tmr_us + 16'd1;
            end
        end else begin
            r_nxt.tmr_div = 8'h00;
            r_nxt.tmr_us = 16'h0;
        end

        // Event collection; status only records occurrence, no order
        set_vec = event_in;
        set_vec[ST_DMA_BIT] = event_in[ST_DMA_BIT] | dma_done_event;
        for (int k = 0; k < NCAT; k++) begin
            if (k == CAT_ATL && r_r.tmo_en) begin
                // Bulk completions wait for the interval to expire
                if (cat_fire[k]) begin
                    r_nxt.atl_pend = 1'b1;
                end
                if (expire && (r_r.atl_pend || cat_fire[k])) begin
                    set_vec[ST_CAT_LSB + k] = 1'b1;
                    r_nxt.atl_pend = 1'b0;
                end
            end else if (cat_fire[k]) begin
                set_vec[ST_CAT_LSB + k] = 1'b1;
            end
        end
        if (!r_r.tmo_en) begin
            r_nxt.atl_pend = 1'b0;
        end
        r_nxt.and_q = and_hit;

        // Register writes
        if (wr) begin
            case (paddr)
                REG_HW_MODE: r_nxt.mode = pwdata[2:0];
                REG_EDGE_CNT: begin
                    r_nxt.pw = pwdata[EC_PW_LSB +: 16];
                    r_nxt.sp = pwdata[EC_SP_LSB +: 8];
                end
                REG_STATUS: clr_vec = pwdata[ST_W-1:0];
                REG_ENABLE: r_nxt.en = pwdata[ST_W-1:0];
                REG_ATL_TMO: begin
                    r_nxt.tmo = pwdata[15:0];
                    r_nxt.tmo_en = pwdata[TMO_EN_BIT];
                end
                default: begin
                    for (int k = 0; k < NCAT; k++) begin
                        ca = 12'(REG_CAT_BASE + REG_CAT_STRIDE * 12'(k));
                        if (paddr == 12'(ca + REG_DONE_OFS)) begin
                            // Done map bits are write-one-to-clear too
                            r_nxt.done[k] = r_r.done[k] & ~pwdata[DONE_W-1:0];
                        end
                        if (paddr == 12'(ca + REG_AND_OFS)) begin
                            r_nxt.andm[k] = pwdata[DONE_W-1:0];
                        end
                        if (paddr == 12'(ca + REG_OR_OFS)) begin
                            r_nxt.orm[k] = pwdata[DONE_W-1:0];
                        end
                    end
                end
            endcase
        end

        // Done maps record completions; a new completion wins over a clear
        for (int k = 0; k < NCAT; k++) begin
            r_nxt.done[k] = r_nxt.done[k] | done_set[k];
        end

        // Write-one-to-clear, hardware set wins over a same-cycle clear
        r_nxt.st = (r_r.st & ~clr_vec) | set_vec;

        // Fresh enabled event kicks the pulse shaper; disabled ones stay silent
        r_nxt.trig = |(set_vec & r_r.en);
    end

    // Register core state; pclk is the always-on clock, so suspend leaves it running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '{mode: MODE_RST, pw: PW_DEF_CODE, sp: 8'h00, st: '0, en: '0,
                     done: '0, andm: '0, orm: '0, and_q: '0, tmo: 16'h0,
                     tmo_en: 1'b0, tmr_us: 16'h0, tmr_div: 8'h00, atl_pend: 1'b0,
                     trig: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // Shaper controls; raw request is global enable with any enabled pending bit
    assign sif.raw = r_r.mode[MODE_GIE_BIT] && |(r_r.st & r_r.en);
    assign sif.trig = r_r.trig && r_r.mode[MODE_GIE_BIT];
    assign sif.gie = r_r.mode[MODE_GIE_BIT];
    assign sif.edge_sel = r_r.mode[MODE_EDGE_BIT];
    assign sif.pol_high = r_r.mode[MODE_POL_BIT];
    assign sif.pw_code = r_r.pw;
    assign sif.sp_code = r_r.sp;

    uhi_irq_shaper #(
        .PW_SCALE(PW_SCALE),
        .SP_UNIT(SP_UNIT)
    ) u_shaper (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // Outputs come from registers
    assign prdata = r_r.prdata;
    assign pready = r_r.pready;
    assign pslverr = r_r.pslverr;
    assign irq = sif.pin;

endmodule // uhi_irq_gen
`default_nettype wire

// ==== sim/uhi_irq_gen_checker.sv ====
// Checker: APB timing and IRQ pin relations of the generator top
`timescale 1ns/1ns
`default_nettype none
module uhi_irq_gen_checker
    import uhi_pkg::*;
#(
    parameter int PW_SCALE = PW_SCALE_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events and pin
    input wire logic [ST_W-1:0] event_in,
    input wire logic irq
);
    logic [2:0] mode_r;
    logic [15:0] en_r;
    logic [15:0] pw_r;
    logic [7:0] sp_r;
    logic [31:0] cnt_r;
    logic wr_ok;
    logic act;
    assign wr_ok = psel && penable && pready && pwrite;
    assign act = (irq == mode_r[MODE_POL_BIT]);
    // Shadow of control words; follows a write at the edge it lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RST;
            en_r <= 16'h0000;
            pw_r <= PW_DEF_CODE;
            sp_r <= 8'h00;
        end else if (wr_ok) begin
            if (paddr == REG_HW_MODE) mode_r <= pwdata[2:0];
            if (paddr == REG_ENABLE) en_r <= pwdata[15:0];
            if (paddr == REG_EDGE_CNT) pw_r <= pwdata[15:0];
            if (paddr == REG_EDGE_CNT) sp_r <= pwdata[31:24];
        end
    end
    // Length of the current active run, so width needs no long repetition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_r <= 32'h0;
        else cnt_r <= act ? cnt_r + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (psel && !penable && paddr > REG_ATL_TMO
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    gie_off_quiet_a: assert property (!mode_r[MODE_GIE_BIT] && $stable(mode_r)
        && $past(mode_r, 2) == mode_r |-> !act) else $error("irq active while disabled");
    pulse_width_a: assert property (mode_r[1:0] == 2'b11 && $stable(mode_r) && $past(act)
        && $past(mode_r, 2) == mode_r && !act
        |-> cnt_r == (32'(pw_r) + 32'h1) * 32'(PW_SCALE)) else $error("pulse width wrong");
    level_hold_a: assert property (mode_r[1:0] == 2'b01 && act && !wr_ok && !$past(wr_ok)
        && !$past(wr_ok, 2) |=> act) else $error("level irq dropped uncleared");
    level_raise_a: assert property (mode_r[1:0] == 2'b01 && sp_r == 8'h00
        && (event_in & en_r) != 16'h0 && !wr_ok && !$past(wr_ok) |-> ##[1:3] act)
        else $error("enabled event did not raise irq");
    cover property (wr_ok && paddr == REG_STATUS);
    cover property (mode_r[1:0] == 2'b11 && $fell(act));
    cover property (pslverr);
endmodule // uhi_irq_gen_checker
bind uhi_irq_gen uhi_irq_gen_checker #(.PW_SCALE(PW_SCALE)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .irq(irq)
);
`default_nettype wire

// ==== sim/uhi_host_irq_model.sv ====
// Host interrupt input model: counts activations and measures their width
`timescale 1ns/1ns
`default_nettype none
module uhi_host_irq_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin and the polarity the host is set up for
    input wire logic irq,
    input wire logic active_high,
    // Observations for the bench
    output var int act_count,
    output var int last_width
);
    logic act_d;
    int run;
    // Sampled input; polarity follows the host setup, matched by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_d <= 1'b0;
            run <= 0;
            act_count <= 0;
            last_width <= 0;
        end else begin
            act_d <= (irq === active_high);
            if (irq === active_high) begin
                run <= run + 1;
                if (!act_d) act_count <= act_count + 1;
            end else if (act_d) begin
                last_width <= run;
                run <= 0;
            end
        end
    end
endmodule // uhi_host_irq_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Testbench: registers, level, pulse, masks and bulk timeout of the IRQ generator
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import uhi_pkg::*;
;
    localparam int PWS = 1;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } uhi_row_t;
    uhi_row_t rows [8] = '{
        '{REG_HW_MODE, 32'hffffffff, 32'h00000007, 1'b0},
        '{REG_EDGE_CNT, 32'hffffffff, 32'hff00ffff, 1'b0},
        '{REG_ENABLE, 32'hffffffff, 32'h0000ffff, 1'b0},
        '{12'h014, 32'hffffffff, 32'hffffffff, 1'b0},
        '{12'h030, 32'h12345678, 32'h12345678, 1'b0},
        '{REG_ATL_TMO, 32'hffffffff, 32'h8000ffff, 1'b0},
        '{12'h038, 32'hffffffff, 32'h00000000, 1'b1},
        '{12'hffc, 32'h00000000, 32'h00000000, 1'b1}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dma_ev, re, host_high;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, iso_d, int_d, blk_d;
    logic [ST_W-1:0] event_in;
    int miscompares, compares, host_cnt, host_w, n1;
    uhi_irq_gen #(.DONE_W(32), .PW_SCALE(PWS), .SP_UNIT(2)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_in(event_in), .dma_done_event(dma_ev), .iso_done_set(iso_d),
        .int_done_set(int_d), .async_bulk_list_done_set(blk_d), .irq(irq));
    uhi_host_irq_model host (.pclk(pclk), .presetn(presetn), .irq(irq),
        .active_high(host_high), .act_count(host_cnt), .last_width(host_w));
    // Free-running 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic summarize();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 32'h0, 32'h1);
        if (n >= 20) summarize();
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, rv, x);
    endtask
    // Kind 0 event, 1 DMA, 2 iso, 3 int, 4 bulk: one-cycle pulse
    task automatic pulse(input int k, input logic [31:0] m);
        if (k == 0) event_in <= m[15:0];
        if (k == 1) dma_ev <= m[0];
        if (k == 2) iso_d <= m;
        if (k == 3) int_d <= m;
        if (k == 4) blk_d <= m;
        @(posedge pclk);
        event_in <= 16'h0000;
        dma_ev <= 1'b0;
        iso_d <= 32'h0;
        int_d <= 32'h0;
        blk_d <= 32'h0;
        @(posedge pclk);
    endtask
    // Bounded wait for a pin level; running out counts as a mismatch
    task automatic wait_irq(input logic lvl, input int lim);
        int n;
        n = 0;
        while (irq !== lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("irq", 32'(irq), 32'(lvl));
        if (n >= lim) summarize();
    endtask
    initial begin
        {presetn, psel, penable, pwrite, dma_ev, host_high} = 6'h00;
        {paddr, pwdata, iso_d, int_d, blk_d, event_in} = 0;
        miscompares = 0;
        compares = 0;
        repeat (10) @(posedge pclk);
        chk("irq in reset", 32'(irq), 32'h1);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("mode", REG_HW_MODE, 32'h0);
        rd("edge cnt", REG_EDGE_CNT, 32'h00000028);
        // Table: write, read back, refusal of unmapped places
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("werr", 32'(re), 32'(rows[i].e));
            rd("row", rows[i].a, rows[i].x);
            chk("rerr", 32'(re), 32'(rows[i].e));
        end
        wr(REG_HW_MODE, 32'h0);
        wr(12'h014, 32'h0);
        wr(12'h030, 32'h0);
        wr(REG_ATL_TMO, 32'h0);
        wr(REG_EDGE_CNT, 32'h00000007);
        // Level mode, active low; disabled source only records
        wr(REG_ENABLE, 32'h1);
        pulse(0, 32'h1);
        repeat (4) @(posedge pclk);
        chk("irq gie off", 32'(irq), 32'h1);
        wr(REG_HW_MODE, 32'h1);
        wait_irq(1'b0, 8);
        pulse(0, 32'h20);
        rd("status", REG_STATUS, 32'h21);
        wr(REG_STATUS, 32'h20);
        repeat (4) @(posedge pclk);
        chk("irq held", 32'(irq), 32'h0);
        rd("status", REG_STATUS, 32'h1);
        wr(REG_STATUS, 32'h1);
        wait_irq(1'b1, 8);
        // Active high polarity
        wr(REG_HW_MODE, 32'h5);
        repeat (3) @(posedge pclk);
        chk("irq idle high pol", 32'(irq), 32'h0);
        pulse(0, 32'h1);
        wait_irq(1'b1, 8);
        wr(REG_STATUS, 32'h1);
        wait_irq(1'b0, 8);
        // Pulse mode: a clear inside the pulse does not shorten it
        wr(REG_HW_MODE, 32'h3);
        wait_irq(1'b1, 8);
        pulse(0, 32'h1);
        wait_irq(1'b0, 8);
        wr(REG_STATUS, 32'h1);
        wait_irq(1'b1, 10);
        @(posedge pclk);
        chk("width", 32'(host_w), 32'((7 + 1) * PWS));
        // Spacing: events inside the pulse merge into one later pulse after the gap
        wr(REG_EDGE_CNT, 32'h02000003);
        wr(REG_ENABLE, 32'h7);
        n1 = host_cnt;
        pulse(0, 32'h1);
        pulse(0, 32'h2);
        pulse(0, 32'h4);
        repeat (40) @(posedge pclk);
        chk("pulses", 32'(host_cnt - n1), 32'h2);
        wr(REG_STATUS, 32'hffff);
        wr(REG_HW_MODE, 32'h0);
        wr(REG_EDGE_CNT, 32'h00000003);
        // DMA end event
        wr(REG_ENABLE, 32'h388);
        wr(REG_HW_MODE, 32'h1);
        pulse(1, 32'h1);
        wait_irq(1'b0, 8);
        rd("status", REG_STATUS, 32'h8);
        wr(REG_STATUS, 32'h8);
        wait_irq(1'b1, 8);
        // Masks: AND waits for all, OR wins, categories apart
        wr(12'h014, 32'h16);
        wr(12'h018, 32'h100);
        pulse(2, 32'h6);
        repeat (4) @(posedge pclk);
        rd("status", REG_STATUS, 32'h0);
        pulse(2, 32'h10);
        wait_irq(1'b0, 8);
        rd("status", REG_STATUS, 32'h80);
        rd("iso done", 12'h010, 32'h16);
        wr(REG_STATUS, 32'h80);
        wr(12'h010, 32'h16);
        wait_irq(1'b1, 8);
        pulse(3, 32'h100);
        repeat (4) @(posedge pclk);
        rd("status", REG_STATUS, 32'h0);
        pulse(2, 32'h100);
        wait_irq(1'b0, 8);
        rd("status", REG_STATUS, 32'h80);
        wr(REG_STATUS, 32'h80);
        wr(12'h010, 32'hffffffff);
        wr(12'h01c, 32'hffffffff);
        wait_irq(1'b1, 8);
        // Bulk interval: report only at timeout expiry
        wr(12'h030, 32'h1);
        wr(REG_ATL_TMO, 32'h80000000);
        pulse(4, 32'h1);
        wait_irq(1'b0, 300);
        wr(REG_STATUS, 32'h200);
        wr(12'h028, 32'h1);
        pulse(4, 32'h1);
        repeat (20) @(posedge pclk);
        chk("irq held back", 32'(irq), 32'h1);
        rd("status", REG_STATUS, 32'h0);
        wait_irq(1'b0, 300);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
